// ==== hw/fps_host.sv ====
`timescale 1ns/1ps
// Functional notes
// - suspend: write B0H, poll toggle bit until steady, then access
// - resume with 30H; erase continues; may suspend again
// - after resume, wait 10 ms when suspends may exceed 1024
// - chip enable deasserted and reasserted around each status read
// - polled reads use target address; toggle reads any address
module fps_host #(
    parameter int RESUME_CYCLES = fps_pkg::RESUME_CYC,
    parameter int PROG_TIMEOUT = fps_pkg::TO_PROG_CYC,
    parameter longint ERASE_TIMEOUT = fps_pkg::TO_ERASE_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // user command port
    input wire logic cmdValid,
    input wire logic [2:0] cmdOp,
    input wire logic [18:0] cmdAddr,
    input wire logic [7:0] cmdData,
    output logic cmdReady,
    output logic doneValid,
    output logic [1:0] doneCode,
    output logic [7:0] doneData,
    // flash pins
    output logic [18:0] flashAddr,
    output logic ceN,
    output logic oeN,
    output logic weN,
    output logic [7:0] dqOut,
    output logic dqOe,
    input wire logic [7:0] dqIn
);
    typedef enum {IDLE, WR_LO, WR_HI, RD_LO, RD_HI, DECIDE, WAIT_RES} fps_state_t;
    fps_state_t state;
    logic [7:0] dqSync1, dqSync2, lastStatus, expData;
    logic havePrev, isErase, keepGoing;
    logic [2:0] op;
    logic [3:0] phaseCnt;
    logic [63:0] toCnt;
    logic [10:0] suspCnt;
    logic [23:0] resumeWait;
    logic toggleSteady, pollDone, timedOut;

    // ****************************************************************
    // pin synchroniser for read data
    // ****************************************************************
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dqSync1 <= 8'h00;
            dqSync2 <= 8'h00;
        end
        else
        begin
            dqSync1 <= dqIn;
            dqSync2 <= dqSync1;
        end
    end

    // completion tests on the newest status byte
    assign toggleSteady = havePrev &&
        (dqSync2[fps_pkg::TOGGLE_BIT] == lastStatus[fps_pkg::TOGGLE_BIT]);
    assign pollDone = isErase ? dqSync2[fps_pkg::POLL_BIT]
                              : (dqSync2[fps_pkg::POLL_BIT] == expData[fps_pkg::POLL_BIT]);

    // another status read is needed while the operation is still busy
    always_comb
    begin
        keepGoing = 1'b0;
        if (op == fps_pkg::OP_SUSPEND)
            keepGoing = !toggleSteady;
        else if (op != fps_pkg::OP_READ)
            keepGoing = !pollDone;
    end

    // status loop limit, longer for erase than for program
    assign timedOut = isErase ? (toCnt >= 64'(ERASE_TIMEOUT))
                              : (toCnt >= 64'(PROG_TIMEOUT));

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= IDLE;
            cmdReady <= 1'b0;
            doneValid <= 1'b0;
            doneCode <= fps_pkg::RES_OK;
            doneData <= 8'h00;
            flashAddr <= 19'h00000;
            ceN <= 1'b1;
            oeN <= 1'b1;
            weN <= 1'b1;
            dqOut <= 8'h00;
            dqOe <= 1'b0;
            phaseCnt <= 4'h0;
            toCnt <= 64'h0;
            lastStatus <= 8'h00;
            expData <= 8'h00;
            havePrev <= 1'b0;
            isErase <= 1'b0;
            op <= 3'h0;
            suspCnt <= 11'h000;
            resumeWait <= 24'h000000;
        end
        else
        begin
            doneValid <= 1'b0;
            unique case (state)
                IDLE:
                begin
                    cmdReady <= 1'b1;
                    if (cmdValid && cmdReady)
                    begin
                        cmdReady <= 1'b0;
                        op <= cmdOp;
                        flashAddr <= cmdAddr;
                        expData <= cmdData;
                        havePrev <= 1'b0;
                        toCnt <= 64'h0;
                        phaseCnt <= 4'h0;
                        isErase <= (cmdOp == fps_pkg::OP_CHIP_ERASE) ||
                                   (cmdOp == fps_pkg::OP_SECTOR_ERASE);
                        unique case (cmdOp)
                            fps_pkg::OP_READ: state <= RD_LO;
                            fps_pkg::OP_SUSPEND:
                            begin
                                dqOut <= fps_pkg::CMD_SUSPEND;
                                state <= WR_LO;
                            end
                            fps_pkg::OP_RESUME:
                            begin
                                dqOut <= fps_pkg::CMD_RESUME;
                                state <= WR_LO;
                            end
                            default:
                            begin
                                dqOut <= cmdData;
                                state <= WR_LO;
                            end
                        endcase
                    end
                end
                WR_LO:
                begin
                    ceN <= 1'b0;
                    weN <= 1'b0;
                    dqOe <= 1'b1;
                    phaseCnt <= phaseCnt + 4'h1;
                    if (phaseCnt == 4'(fps_pkg::PHASE_CYC))
                    begin
                        phaseCnt <= 4'h0;
                        state <= WR_HI;
                    end
                end
                WR_HI:
                begin
                    weN <= 1'b1;
                    ceN <= 1'b1;
                    phaseCnt <= phaseCnt + 4'h1;
                    if (phaseCnt == 4'(fps_pkg::PHASE_CYC))
                    begin
                        dqOe <= 1'b0;
                        phaseCnt <= 4'h0;
                        if (op == fps_pkg::OP_WRITE)
                        begin
                            doneCode <= fps_pkg::RES_OK;
                            doneValid <= 1'b1;
                            state <= IDLE;
                        end
                        else if (op == fps_pkg::OP_RESUME)
                        begin
                            suspCnt <= (suspCnt == 11'(fps_pkg::SUSP_LIMIT)) ? suspCnt
                                                                           : suspCnt + 11'h001;
                            resumeWait <= 24'h000000;
                            state <= WAIT_RES;
                        end
                        else
                            state <= RD_LO;
                    end
                end
                RD_LO:
                begin
                    ceN <= 1'b0;
                    oeN <= 1'b0;
                    toCnt <= toCnt + 64'h1;
                    phaseCnt <= phaseCnt + 4'h1;
                    if (phaseCnt == 4'(fps_pkg::PHASE_CYC) + 4'h2)
                    begin
                        phaseCnt <= 4'h0;
                        state <= DECIDE;
                    end
                end
                DECIDE:
                begin
                    ceN <= 1'b1;
                    oeN <= 1'b1;
                    lastStatus <= dqSync2;
                    havePrev <= 1'b1;
                    doneData <= dqSync2;
                    if (keepGoing && !timedOut)
                        state <= RD_LO;
                    else
                    begin
                        // a loop cut short by its limit reports timeout
                        doneCode <= keepGoing ? fps_pkg::RES_TIMEOUT : fps_pkg::RES_OK;
                        doneValid <= 1'b1;
                        state <= IDLE;
                    end
                end
                WAIT_RES:
                begin
                    resumeWait <= resumeWait + 24'h000001;
                    if ((suspCnt < 11'(fps_pkg::SUSP_LIMIT)) ||
                        (resumeWait >= 24'(RESUME_CYCLES)))
                    begin
                        doneCode <= fps_pkg::RES_OK;
                        doneValid <= 1'b1;
                        state <= IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_ce_fresh: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == DECIDE) |=> ceN)
        else $error("chip enable not released between status reads");
    chk_suspend_byte: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == WR_LO && op == fps_pkg::OP_SUSPEND) |-> dqOut == fps_pkg::CMD_SUSPEND)
        else $error("suspend byte wrong");
    chk_resume_byte: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == WR_LO && op == fps_pkg::OP_RESUME) |-> dqOut == fps_pkg::CMD_RESUME)
        else $error("resume byte wrong");
    chk_resume_wait: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == WAIT_RES && suspCnt == 11'(fps_pkg::SUSP_LIMIT) &&
         resumeWait < 24'(RESUME_CYCLES)) |=> !doneValid)
        else $error("resume delay skipped");
    chk_no_drive_read: assert property (@(posedge mclk) disable iff (!rst_n)
        !oeN |-> !dqOe)
        else $error("bus contention on read");
    chk_we_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(weN) |-> !weN [*3])
        else $error("write pulse too short");
    chk_poll_done: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == DECIDE && op == fps_pkg::OP_PROGRAM && !pollDone && !toggleSteady
         && toCnt < 64'(PROG_TIMEOUT)) |=> !doneValid)
        else $error("program ended early");
    chk_erase_done: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == DECIDE && isErase && !dqSync2[fps_pkg::POLL_BIT]
         && toCnt < 64'(ERASE_TIMEOUT)) |=> !doneValid)
        else $error("erase ended early");
    cov_program: cover property (@(posedge mclk) disable iff (!rst_n)
        doneValid && op == fps_pkg::OP_PROGRAM);
    cov_erase: cover property (@(posedge mclk) disable iff (!rst_n)
        doneValid && op == fps_pkg::OP_SECTOR_ERASE);
    cov_suspend: cover property (@(posedge mclk) disable iff (!rst_n)
        doneValid && op == fps_pkg::OP_SUSPEND);
endmodule : fps_host

// ==== include/fps_pkg.sv ====
package fps_pkg;
    // ****************************************************************
    // timing and command constants
    // ****************************************************************
    localparam int CLK_MHZ = 25;
    localparam int CLK_NS = 40;
    // bus cycle phase length, covers write pulse, access time and hold
    localparam int PHASE_NS = 120;
    localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
    // delay after resume
    localparam int RESUME_MS = 10;
    localparam int RESUME_CYC = RESUME_MS * 1000 * CLK_MHZ;
    // timeouts beyond maximum program and erase times
    localparam int PROG_MAX_US = 300;
    localparam int CHIP_ERASE_MAX_S = 32;
    localparam int TO_PROG_CYC = 2 * PROG_MAX_US * CLK_MHZ;
    localparam longint TO_ERASE_CYC = 2 * longint'(CHIP_ERASE_MAX_S) * 1000000 * CLK_MHZ;
    localparam int SUSP_LIMIT = 1024;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    // host command codes
    localparam logic [2:0] OP_PROGRAM = 3'h0;
    localparam logic [2:0] OP_CHIP_ERASE = 3'h1;
    localparam logic [2:0] OP_SECTOR_ERASE = 3'h2;
    localparam logic [2:0] OP_SUSPEND = 3'h3;
    localparam logic [2:0] OP_RESUME = 3'h4;
    localparam logic [2:0] OP_READ = 3'h5;
    localparam logic [2:0] OP_WRITE = 3'h6;
    // completion codes
    localparam logic [1:0] RES_OK = 2'h0;
    localparam logic [1:0] RES_TIMEOUT = 2'h1;
    localparam logic [1:0] RES_MISMATCH = 2'h2;
endpackage : fps_pkg

// ==== verif/fps_flash_model.sv ====
`timescale 1ns/1ps
// ********
// byte-wide flash device model
// ********
module fps_flash_model #(
    parameter int PROG_NS = 20000,
    parameter int ERASE_NS = 80000,
    parameter logic [7:0] CMD_PROG = 8'hA0,
    parameter logic [7:0] CMD_ESET = 8'h80,
    parameter logic [7:0] CMD_SECT = 8'h30
) (
    // flash pins
    input wire logic [18:0] addr,
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic [7:0] busIn,
    output logic [7:0] busOut
);
    logic [7:0] mem [logic [18:0]];
    logic [7:0] last = 8'h00;
    logic [7:0] pData = 8'h00;
    logic [18:0] pAddr = 19'h00000;
    int kind = 0; // 0 idle, 1 program, 2 chip, 3 sector
    int left = 0;
    logic susp = 1'h0;
    logic tgl = 1'h0;
    logic fresh = 1'h0;
    wire rdN = ceN | oeN | ~weN;
    wire wrN = ceN | weN;
    initial busOut = 8'h00;
    // busy countdown, frozen while suspended
    always #100
    begin
        if (kind != 0 && !susp) left = left - 100;
        if (kind == 1 && left <= 0) mem[pAddr] = pData;
        if (kind == 2 && left <= 0) mem.delete();
        if (kind == 3 && left <= 0)
            foreach (mem[a]) if (a[18:13] == pAddr[18:13]) mem[a] = 8'hFF;
        if (left <= 0) kind = 0;
    end
    // command decode at end of each write strobe
    always @(posedge wrN)
    begin
        if (kind > 1 && busIn == fps_pkg::CMD_SUSPEND) susp = 1'h1;
        else if (susp && busIn == fps_pkg::CMD_RESUME) susp = 1'h0;
        else if (kind == 0 && (last == CMD_PROG || last == CMD_ESET))
        begin
            kind = (last == CMD_PROG) ? 1 : ((busIn == CMD_SECT) ? 3 : 2);
            pAddr = addr;
            pData = busIn;
            left = (kind == 1) ? PROG_NS : ERASE_NS;
        end
        last = busIn;
    end
    // a read is fresh only after chip enable went high
    always @(posedge ceN) fresh = 1'h1;
    // status or array data during each read
    always @(negedge rdN)
    begin
        if (fresh && kind != 0 && !susp) tgl = ~tgl;
        fresh = 1'h0;
        if (kind == 0 || susp) busOut = mem.exists(addr) ? mem[addr] : 8'hFF;
        else if (kind == 1) busOut = {~pData[7], tgl, 6'h00};
        else busOut = {1'h0, tgl, 6'h00};
    end
    // released bus shows inverse of last value
    always @(posedge rdN) busOut = ~busOut;
endmodule : fps_flash_model

// ==== verif/fps_host_bench.sv ====
`timescale 1ns/1ps
// ********
// host sequencer against flash model
// ********
module fps_host_bench;
    typedef struct packed {logic [2:0] op; logic [18:0] a; logic [7:0] d, e, m;} fps_row_t;
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic cmdValid = 1'h0;
    logic [2:0] cmdOp = 3'h0;
    logic [18:0] cmdAddr = 19'h00000;
    logic [7:0] cmdData = 8'h00;
    logic cmdReady, doneValid, ceN, oeN, weN, dqOe;
    logic [1:0] doneCode;
    logic [7:0] doneData, dqOut, busOut;
    logic [18:0] flashAddr;
    wire [7:0] dqIn = dqOe ? dqOut : busOut;
    int n_mismatch = 0;
    int n_tests = 0;
    fps_row_t rows [10] = '{
        '{3'h6, 19'h00000, 8'hA0, 8'h00, 8'h00},
        '{3'h0, 19'h01234, 8'h5A, 8'h5A, 8'hFF},
        '{3'h6, 19'h00000, 8'hA0, 8'h00, 8'h00},
        '{3'h0, 19'h41234, 8'hC3, 8'hC3, 8'hFF},
        '{3'h5, 19'h01234, 8'h00, 8'h5A, 8'hFF},
        '{3'h6, 19'h00000, 8'h80, 8'h00, 8'h00},
        '{3'h2, 19'h01234, 8'h30, 8'hFF, 8'hFF},
        '{3'h5, 19'h41234, 8'h00, 8'hC3, 8'hFF},
        '{3'h6, 19'h00000, 8'h80, 8'h00, 8'h00},
        '{3'h1, 19'h41234, 8'h10, 8'hFF, 8'hFF}
    };
    // 25 MHz clock
    always #20 mclk = ~mclk;
    // design and flash model
    fps_host #(.RESUME_CYCLES(50), .PROG_TIMEOUT(2000), .ERASE_TIMEOUT(5000)) fps_host_i (
        .mclk, .rst_n, .cmdValid, .cmdOp, .cmdAddr, .cmdData, .cmdReady, .doneValid,
        .doneCode, .doneData, .flashAddr, .ceN, .oeN, .weN, .dqOut, .dqOe, .dqIn
    );
    fps_flash_model fps_flash_model_i (
        .addr(flashAddr), .ceN, .oeN, .weN, .busIn(dqIn), .busOut
    );
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_sim();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim
    // one command, bounded wait for completion, code and masked data
    task automatic run_op(input logic [2:0] op, input logic [18:0] a, input logic [7:0] d,
        input logic [7:0] e, input logic [7:0] m, input logic [1:0] c = fps_pkg::RES_OK);
        int n;
        n = 0;
        cmdValid <= 1'h1;
        cmdOp <= op;
        cmdAddr <= a;
        cmdData <= d;
        do
        begin
            @(posedge mclk);
            n++;
        end while (cmdReady !== 1'h1 && n < 20);
        cmdValid <= 1'h0;
        while (doneValid !== 1'h1 && n < 9000)
        begin
            @(posedge mclk);
            n++;
        end
        if (doneValid !== 1'h1)
        begin
            chk("done", 8'h01, 8'h00);
            end_sim();
        end
        else
        begin
            chk("code", {6'h00, c}, {6'h00, doneCode});
            if (m != 8'h00) chk("data", e, doneData & m);
        end
    endtask : run_op
    // reset, table walk, then hand-written cases
    initial
    begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'h1;
        repeat (2) @(posedge mclk);
        chk("ready", 8'h01, {7'h00, cmdReady});
        chk("idle pins", 8'h02, {6'h00, ceN, dqOe});
        $display("test reset done");
        foreach (rows[i]) run_op(rows[i].op, rows[i].a, rows[i].d, rows[i].e, rows[i].m);
        $display("test table done");
        // program in flight reads inverted top bit
        run_op(3'h6, 19'h00000, 8'hA0, 8'h00, 8'h00);
        run_op(3'h6, 19'h02000, 8'h3C, 8'h00, 8'h00);
        run_op(3'h5, 19'h02000, 8'h00, 8'h80, 8'h80);
        repeat (600) @(posedge mclk);
        run_op(3'h5, 19'h02000, 8'h00, 8'h3C, 8'hFF);
        $display("test poll done");
        // erase in flight: suspend, read, resume, twice
        run_op(3'h6, 19'h00000, 8'h80, 8'h00, 8'h00);
        run_op(3'h6, 19'h41234, 8'h10, 8'h00, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            run_op(3'h5, 19'h41234, 8'h00, 8'h00, 8'h80);
            run_op(3'h3, 19'h41234, 8'hB0, 8'h00, 8'h00);
            run_op(3'h5, 19'h02000, 8'h00, 8'h3C, 8'hFF);
            run_op(3'h4, 19'h41234, 8'h30, 8'h00, 8'h00);
        end
        repeat (2500) @(posedge mclk);
        run_op(3'h5, 19'h02000, 8'h00, 8'hFF, 8'hFF);
        $display("test suspend done");
        // program with no unlock prefix never completes
        run_op(3'h0, 19'h01234, 8'h00, 8'h00, 8'h00, fps_pkg::RES_TIMEOUT);
        $display("test timeout done");
        // reset in mid-read returns the pins to idle
        cmdValid <= 1'h1;
        cmdOp <= 3'h5;
        repeat (4) @(posedge mclk);
        cmdValid <= 1'h0;
        rst_n <= 1'h0;
        @(posedge mclk);
        chk("reset pins", 8'h1C, {3'h0, ceN, oeN, weN, dqOe, cmdReady});
        repeat (2) @(posedge mclk);
        rst_n <= 1'h1;
        repeat (2) @(posedge mclk);
        chk("ready again", 8'h01, {7'h00, cmdReady});
        run_op(3'h5, 19'h02000, 8'h00, 8'hFF, 8'hFF);
        $display("test mid reset done");
        end_sim();
    end
endmodule : fps_host_bench
